// ### rtl/jtp_pkg.sv
// Constants and types shared by the test and programming port
// Function
// - Programming data line is bidirectional
// - All programming pin pairs share logic
// - Master clear plus clock enters programming; here master clear low alone enters it
// - Query response returned serially on data line
// - Configuration selects active debugger pin pair
// - Writable bits override peripheral freeze
// - Overridden peripheral keeps sending buffered data
// - Test port works only while enabled
// - Test port enable resets to one
// - Enabled test port owns its four pins
// - Test logic clocked from test clock
// - Controller sequences on test mode select
// - Serial shift in on TDI, out TDO
// - Test registers not in data memory
// - Four-bit instruction register selects data register
// - Instruction shifted LSB first, decoded after
// - Chain fed at first TDI, read last TDO
// - Bypass is one bit between TDI, TDO
// - Identifier shifted out on 32 falling edges
// - Boundary cell holds input, output, control stages
package jtp_pkg;

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	localparam int           IR_W       = 4;
	localparam logic [3:0]   IR_HIGHZ   = 4'h0;
	localparam logic [3:0]   IR_IDCODE  = 4'h1;
	localparam logic [3:0]   IR_SAMPLE  = 4'h2;
	localparam logic [3:0]   IR_EXTEST  = 4'h6;
	localparam logic [3:0]   IR_BYPASS  = 4'hf;
	localparam logic [3:0]   IR_CAPTURE = 4'h1;

	// ----------------------------------------------------------------
	// Debug port control word
	// ----------------------------------------------------------------
	localparam int           DPC_W         = 8;
	localparam logic [7:0]   DPC_RESET     = 8'h0c;
	localparam logic [7:0]   DPC_MASK      = 8'h7c;
	localparam int           DPC_U1_BIT    = 6;
	localparam int           DPC_U2_BIT    = 5;
	localparam int           DPC_SPI1_BIT  = 4;
	localparam int           DPC_TPEN_BIT  = 3;
	localparam int           DPC_TRACE_BIT = 2;

	// ----------------------------------------------------------------
	// Data registers and programming link
	// ----------------------------------------------------------------
	localparam int           ID_W      = 32;
	localparam int           BS_STAGES = 3;
	localparam int           BS_IN     = 0;
	localparam int           BS_OUT    = 1;
	localparam int           BS_CTL    = 2;
	localparam int           PG_W      = 8;
	localparam logic [2:0]   PG_LAST   = 3'd7;

	typedef enum logic [3:0] {
		TS_TLR, TS_RTI,
		TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR, TS_UPD_DR,
		TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UPD_IR
	} jtp_tap_state_t;

endpackage : jtp_pkg

// ### rtl/jtp_pkg_ref_guard.sv
// Intentionally minimal: no extra content
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### rtl/jtp_tap_fsm.sv
// Sixteen-state test access controller
`timescale 1ns/100ps
`default_nettype none
module jtp_tap_fsm
	import jtp_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	jtp_tap_if.fsm    tif
);

	typedef struct packed {
		jtp_tap_state_t st;
	} jtp_fsm_t;

	jtp_fsm_t q;
	jtp_fsm_t d;

	always_comb
	begin
		d = q;
		if (tif.step)
		begin
			case (q.st)
				TS_TLR:    d.st = tif.tms ? TS_TLR    : TS_RTI;
				TS_RTI:    d.st = tif.tms ? TS_SEL_DR : TS_RTI;
				TS_SEL_DR: d.st = tif.tms ? TS_SEL_IR : TS_CAP_DR;
				TS_CAP_DR: d.st = tif.tms ? TS_EX1_DR : TS_SH_DR;
				TS_SH_DR:  d.st = tif.tms ? TS_EX1_DR : TS_SH_DR;
				TS_EX1_DR: d.st = tif.tms ? TS_UPD_DR : TS_PA_DR;
				TS_PA_DR:  d.st = tif.tms ? TS_EX2_DR : TS_PA_DR;
				TS_EX2_DR: d.st = tif.tms ? TS_UPD_DR : TS_SH_DR;
				TS_UPD_DR: d.st = tif.tms ? TS_SEL_DR : TS_RTI;
				TS_SEL_IR: d.st = tif.tms ? TS_TLR    : TS_CAP_IR;
				TS_CAP_IR: d.st = tif.tms ? TS_EX1_IR : TS_SH_IR;
				TS_SH_IR:  d.st = tif.tms ? TS_EX1_IR : TS_SH_IR;
				TS_EX1_IR: d.st = tif.tms ? TS_UPD_IR : TS_PA_IR;
				TS_PA_IR:  d.st = tif.tms ? TS_EX2_IR : TS_PA_IR;
				TS_EX2_IR: d.st = tif.tms ? TS_UPD_IR : TS_SH_IR;
				TS_UPD_IR: d.st = tif.tms ? TS_SEL_DR : TS_RTI;
				default:   d.st = TS_TLR;
			endcase
		end
		// Disabled port parks in reset so it wakes up clean
		if (!rstn || tif.clr)
			d.st = TS_TLR;
	end

	always_ff @(posedge clk_sys)
		q <= d;

	assign tif.state = q.st;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_clr_parks;
		@(posedge clk_sys) disable iff (!rstn)
		tif.clr |=> (q.st == TS_TLR);
	endproperty
	a_clr_parks: assert property (p_clr_parks) else $error("cleared controller not in reset");

	property p_shift_ir_holds;
		@(posedge clk_sys) disable iff (!rstn)
		(q.st == TS_SH_IR && tif.step && !tif.tms && !tif.clr) |=> (q.st == TS_SH_IR);
	endproperty
	a_shift_ir_holds: assert property (p_shift_ir_holds) else $error("left IR shift on low mode");

endmodule : jtp_tap_fsm
`default_nettype wire

// ### rtl/jtp_tap_if.sv
// Interface between the port core and its controller state machine
`timescale 1ns/100ps
`default_nettype none
interface jtp_tap_if;
	import jtp_pkg::*;
	logic           step;
	logic           tms;
	logic           clr;
	jtp_tap_state_t state;

	modport core (output step, output tms, output clr, input state);
	modport fsm  (input step, input tms, input clr, output state);
endinterface : jtp_tap_if
`default_nettype wire

// ### rtl/jtp_top.sv
// Test access port and two-wire programming port
`timescale 1ns/100ps
`default_nettype none
module jtp_top
	import jtp_pkg::*;
#(
	parameter int          NP         = 2,
	parameter int          BS_PINS    = 8,
	parameter logic [31:0] ID_CODE    = 32'h0a5c_3001, // Arbitrary identifier value
	parameter logic [7:0]  PG_QUERY   = 8'h5a,
	localparam int         PSEL_W     = (NP > 1) ? $clog2(NP) : 1,
	localparam int         BSW        = BS_STAGES * BS_PINS
)
(
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	input  wire logic               tck_pin,
	input  wire logic               tms_pin,
	input  wire logic               tdi_pin,
	output logic                    tdo_out,
	output logic                    tdo_oe,
	output logic                    test_pins_owned,
	input  wire logic [NP-1:0]      prog_clock_pin_of_pair,
	input  wire logic [NP-1:0]      prog_data_pin_of_pair_in,
	output logic      [NP-1:0]      prog_data_pin_of_pair_out,
	output logic      [NP-1:0]      prog_data_pin_of_pair_oe,
	input  wire logic               master_clear_pin_n,
	input  wire logic [PSEL_W-1:0]  debugger_pair_select,
	input  wire logic               debug_enable,
	output logic      [PG_W-1:0]    prog_cmd,
	output logic                    prog_cmd_valid,
	input  wire logic [PG_W-1:0]    prog_resp_data,
	input  wire logic               ctl_we,
	input  wire logic [DPC_W-1:0]   ctl_wdata,
	output logic      [DPC_W-1:0]   debug_port_control_reg,
	input  wire logic               debug_halt,
	output logic      [2:0]         periph_freeze,
	input  wire logic [BS_PINS-1:0] pin_in,
	input  wire logic [BS_PINS-1:0] gpio_out,
	input  wire logic [BS_PINS-1:0] gpio_oe,
	output logic      [BS_PINS-1:0] pin_out,
	output logic      [BS_PINS-1:0] pin_oe
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic               tck_s1;
		logic               tck_s2;
		logic               tck_s3;
		logic               tms_s1;
		logic               tms_s2;
		logic               tdi_s1;
		logic               tdi_s2;
		logic               mrst_s1;
		logic               mrst_s2;
		logic [NP-1:0]      pclk_s1;
		logic [NP-1:0]      pclk_s2;
		logic               pclk_prev;
		logic [NP-1:0]      pdat_s1;
		logic [NP-1:0]      pdat_s2;
		logic [BS_PINS-1:0] pin_s1;
		logic [BS_PINS-1:0] pin_s2;
		logic [IR_W-1:0]    ir_sh;
		logic [IR_W-1:0]    ir;
		logic               byp;
		logic [ID_W-1:0]    id_sh;
		logic [BSW-1:0]     bs_sh;
		logic [BS_PINS-1:0] bs_out;
		logic [BS_PINS-1:0] bs_ctl;
		logic               tdo;
		logic               tdo_oe;
		logic [DPC_W-1:0]   dpc;
		logic [PG_W-1:0]    pg_sh;
		logic [2:0]         pg_cnt;
		logic [PG_W-1:0]    pg_cmd;
		logic               pg_vld;
		logic [PG_W-1:0]    pg_resp;
		logic               pg_tx;
		logic               pg_bit;
		logic               pg_oe;
	} jtp_state_t;

	jtp_state_t q;
	jtp_state_t d;

	jtp_tap_if tif ();

	jtp_tap_fsm u_fsm (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tif     (tif)
	);

	// ----------------------------------------------------------------
	// Edges and selection
	// ----------------------------------------------------------------
	logic          tpen;
	logic          tck_rise;
	logic          tck_fall;
	logic          prog_mode;
	logic          dbg_mode;
	logic [NP-1:0] pair_mask;
	logic          pg_clk;
	logic          pg_din;
	logic          pg_rise;
	logic          pg_fall;
	logic          dr_tdo;

	assign tpen     = q.dpc[DPC_TPEN_BIT];
	// Test logic moves on a sampled test clock edge, except that it parks in reset while the port is disabled
	assign tck_rise = q.tck_s2 & ~q.tck_s3;
	assign tck_fall = ~q.tck_s2 & q.tck_s3;
	assign tif.step = tck_rise & tpen;
	assign tif.tms  = q.tms_s2;
	assign tif.clr  = ~tpen;

	// Master clear low puts the link in programming mode
	assign prog_mode = ~q.mrst_s2;
	assign dbg_mode  = debug_enable & ~prog_mode;

	// Programming listens on every pair; debug only on the chosen one
	always_comb
	begin
		pair_mask = '0;
		if (prog_mode)
			pair_mask = '1;
		else if (dbg_mode)
			pair_mask[debugger_pair_select] = 1'b1;
	end

	assign pg_clk  = |(q.pclk_s2 & pair_mask);
	assign pg_din  = |(q.pdat_s2 & pair_mask);
	assign pg_rise = pg_clk & ~q.pclk_prev;
	assign pg_fall = ~pg_clk & q.pclk_prev;

	// Unknown instructions fall back to the bypass bit
	always_comb
	begin
		case (q.ir)
			IR_IDCODE:  dr_tdo = q.id_sh[0];
			IR_SAMPLE:  dr_tdo = q.bs_sh[0];
			IR_EXTEST:  dr_tdo = q.bs_sh[0];
			default:    dr_tdo = q.byp;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.tck_s1  = tck_pin;
		d.tck_s2  = q.tck_s1;
		d.tck_s3  = q.tck_s2;
		d.tms_s1  = tms_pin;
		d.tms_s2  = q.tms_s1;
		d.tdi_s1  = tdi_pin;
		d.tdi_s2  = q.tdi_s1;
		d.mrst_s1 = master_clear_pin_n;
		d.mrst_s2 = q.mrst_s1;
		d.pclk_s1  = prog_clock_pin_of_pair;
		d.pclk_s2  = q.pclk_s1;
		d.pclk_prev = pg_clk;
		d.pdat_s1  = prog_data_pin_of_pair_in;
		d.pdat_s2  = q.pdat_s1;
		d.pin_s1  = pin_in;
		d.pin_s2  = q.pin_s1;
		d.pg_vld  = 1'b0;

		if (ctl_we)
			d.dpc = ctl_wdata & DPC_MASK;

		// Rising test clock: capture and shift
		if (tif.step)
		begin
			case (tif.state)
				TS_CAP_IR: d.ir_sh = IR_CAPTURE;
				TS_SH_IR:  d.ir_sh = {q.tdi_s2, q.ir_sh[IR_W-1:1]};
				TS_CAP_DR:
				begin
					d.byp   = 1'b0;
					d.id_sh = ID_CODE;
					for (int i = 0; i < BS_PINS; i++)
					begin
						d.bs_sh[BS_STAGES*i+BS_IN]  = q.pin_s2[i];
						d.bs_sh[BS_STAGES*i+BS_OUT] = pin_out[i];
						d.bs_sh[BS_STAGES*i+BS_CTL] = pin_oe[i];
					end
				end
				TS_SH_DR:
				begin
					case (q.ir)
						IR_IDCODE: d.id_sh = {q.tdi_s2, q.id_sh[ID_W-1:1]};
						IR_SAMPLE: d.bs_sh = {q.tdi_s2, q.bs_sh[BSW-1:1]};
						IR_EXTEST: d.bs_sh = {q.tdi_s2, q.bs_sh[BSW-1:1]};
						default:   d.byp   = q.tdi_s2;
					endcase
				end
				default:
				begin
				end
			endcase
		end

		// Falling test clock: drive out and update
		if (tck_fall && tpen)
		begin
			if (tif.state == TS_SH_IR)
			begin
				d.tdo    = q.ir_sh[0];
				d.tdo_oe = 1'b1;
			end
			else if (tif.state == TS_SH_DR)
			begin
				d.tdo    = dr_tdo;
				d.tdo_oe = 1'b1;
			end
			else
				d.tdo_oe = 1'b0;
			// Decode only once the whole word has been shifted
			if (tif.state == TS_UPD_IR)
				d.ir = q.ir_sh;
			if (tif.state == TS_UPD_DR && (q.ir == IR_SAMPLE || q.ir == IR_EXTEST))
			begin
				for (int i = 0; i < BS_PINS; i++)
				begin
					d.bs_out[i] = q.bs_sh[BS_STAGES*i+BS_OUT];
					d.bs_ctl[i] = q.bs_sh[BS_STAGES*i+BS_CTL];
				end
			end
		end
		if (!tpen || tif.state == TS_TLR)
		begin
			d.tdo_oe = 1'b0;
			d.ir     = IR_IDCODE;
		end

		// Programming link, byte wide, LSB first
		if (!(prog_mode || dbg_mode))
		begin
			d.pg_cnt = '0;
			d.pg_tx  = 1'b0;
			d.pg_oe  = 1'b0;
		end
		else if (q.pg_tx)
		begin
			if (pg_fall)
			begin
				d.pg_bit  = q.pg_resp[0];
				d.pg_resp = {1'b0, q.pg_resp[PG_W-1:1]};
				d.pg_oe   = 1'b1;
			end
			if (pg_rise && q.pg_oe)
			begin
				d.pg_cnt = q.pg_cnt + 3'd1;
				if (q.pg_cnt == PG_LAST)
				begin
					d.pg_tx  = 1'b0;
					d.pg_oe  = 1'b0;
					d.pg_cnt = '0;
				end
			end
		end
		else if (pg_rise)
		begin
			d.pg_sh  = {pg_din, q.pg_sh[PG_W-1:1]};
			d.pg_cnt = q.pg_cnt + 3'd1;
			if (q.pg_cnt == PG_LAST)
			begin
				d.pg_cmd = {pg_din, q.pg_sh[PG_W-1:1]};
				d.pg_vld = 1'b1;
				d.pg_cnt = '0;
				if ({pg_din, q.pg_sh[PG_W-1:1]} == PG_QUERY)
				begin
					d.pg_tx   = 1'b1;
					d.pg_resp = prog_resp_data;
				end
			end
		end

		if (!rstn)
		begin
			d     = '0;
			d.dpc = DPC_RESET;
			d.ir  = IR_IDCODE;
			d.mrst_s1 = 1'b1;
			d.mrst_s2 = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
		q <= d;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Port registers live here only; nothing maps them into memory
	assign debug_port_control_reg = q.dpc;
	assign tdo_out         = q.tdo;
	assign tdo_oe          = q.tdo_oe;
	assign test_pins_owned = tpen;
	assign prog_cmd        = q.pg_cmd;
	assign prog_cmd_valid  = q.pg_vld;
	assign prog_data_pin_of_pair_out = {NP{q.pg_bit}};
	assign prog_data_pin_of_pair_oe  = pair_mask & {NP{q.pg_oe}};

	// Override lifts the freeze so buffered data keeps draining
	assign periph_freeze = {3{debug_halt}} &
		~{q.dpc[DPC_U1_BIT], q.dpc[DPC_U2_BIT], q.dpc[DPC_SPI1_BIT]};

	always_comb
	begin
		pin_out = gpio_out;
		pin_oe  = gpio_oe;
		if (tpen && q.ir == IR_EXTEST)
		begin
			pin_out = q.bs_out;
			pin_oe  = q.bs_ctl;
		end
		else if (tpen && q.ir == IR_HIGHZ)
			pin_oe = '0;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_tpen_reset;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(rstn) |-> (q.dpc[DPC_TPEN_BIT] && q.ir == IR_IDCODE);
	endproperty
	a_tpen_reset: assert property (p_tpen_reset) else $error("port not enabled after reset");

	property p_disabled_quiet;
		@(posedge clk_sys) disable iff (!rstn)
		!tpen ##1 !tpen |-> !tdo_oe && tif.state == TS_TLR;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled port active");

	property p_ir_update;
		@(posedge clk_sys) disable iff (!rstn)
		(tpen && tck_fall && tif.state == TS_UPD_IR) |=> (q.ir == $past(q.ir_sh));
	endproperty
	a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

	property p_id_capture;
		@(posedge clk_sys) disable iff (!rstn)
		(tif.step && tif.state == TS_CAP_DR) |=> (q.id_sh == ID_CODE);
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("identifier not captured");

	property p_bypass_bit;
		@(posedge clk_sys) disable iff (!rstn)
		(tpen && tck_fall && tif.state == TS_SH_DR && q.ir == IR_BYPASS)
			|=> (tdo_out == $past(q.byp)) && tdo_oe;
	endproperty
	a_bypass_bit: assert property (p_bypass_bit) else $error("bypass bit not on output");

	property p_freeze_override;
		@(posedge clk_sys) disable iff (!rstn)
		(debug_halt && q.dpc[DPC_U1_BIT]) |-> !periph_freeze[2] && (periph_freeze[1] != q.dpc[DPC_U2_BIT]);
	endproperty
	a_freeze_override: assert property (p_freeze_override) else $error("freeze override wrong");

	property p_query_answer;
		@(posedge clk_sys) disable iff (!rstn)
		(prog_cmd_valid && prog_cmd == PG_QUERY && (prog_mode || dbg_mode)) |-> q.pg_tx;
	endproperty
	a_query_answer: assert property (p_query_answer) else $error("query not answered");

endmodule : jtp_top
`default_nettype wire

// ### verification/jtp_tester.sv
// External tester and programmer model driving the test and programming pins
`timescale 1ns/100ps
`default_nettype none
module jtp_tester #(
	parameter int NP = 2
)
(
	input  wire logic          clk_sys,
	input  wire logic          tdo_out,
	input  wire logic [NP-1:0] pd_out,
	input  wire logic [NP-1:0] pd_oe,
	output var logic           tck,
	output var logic           tms,
	output var logic           tdi,
	output var logic           mrst_n,
	output var logic [NP-1:0]  pclk,
	output logic     [NP-1:0]  pdat
);
	logic [NP-1:0] drv;

	// Wire level of each data pin, device wins while it drives
	assign pdat = (pd_oe & pd_out) | (~pd_oe & drv);

	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		mrst_n = 1'b1;
		pclk = '0;
		drv = '0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt

	// ----
	// Test clock idles low; tdo read just before the fall
	// ----
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		wt(4);
		tck = 1'b1;
		wt(4);
		o = tdo_out;
		tck = 1'b0;
	endtask : step

	// From idle through one IR or DR scan and back to idle
	task automatic scan(input logic ir, input logic [31:0] v, input int n,
		output logic [31:0] q);
		logic o;
		q = '0;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, v[i], o);
			q[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask : scan

	// ----
	// Programming pair: data read before each rise
	// ----
	task automatic pbyte(input int p, input logic [7:0] b, output logic [7:0] r);
		for (int i = 0; i < 8; i++)
		begin
			drv[p] = b[i];
			wt(5);
			r[i] = pdat[p];
			pclk[p] = 1'b1;
			wt(3);
			pclk[p] = 1'b0;
		end
	endtask : pbyte
endmodule : jtp_tester
`default_nettype wire

// ### verification/jtp_top_tb.sv
// Self-checking bench for the test and programming port
`timescale 1ns/100ps
`default_nettype none
module jtp_top_tb;
	import jtp_pkg::*;
	localparam logic [31:0] ID = 32'h1234_5671; // Arbitrary identifier value
	logic        clk_sys, rstn, tck, tms, tdi, tdo_out, tdo_oe, owned, mrst_n;
	logic        psel, dbg_en, cmd_v, ctl_we, halt;
	logic [1:0]  pclk, pdat, pd_out, pd_oe;
	logic [7:0]  cmd, resp, wdat, dpc, pin_in, g_out, g_oe, pin_out, pin_oe, last_cmd, r;
	logic [2:0]  frz;
	logic [31:0] q, p;
	int          err_count, samples_checked, nv, oe_seen;

	jtp_top #(.ID_CODE(ID)) i_jtp_top (
		.clk_sys(clk_sys), .rstn(rstn), .tck_pin(tck), .tms_pin(tms),
		.tdi_pin(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .test_pins_owned(owned),
		.prog_clock_pin_of_pair(pclk), .prog_data_pin_of_pair_in(pdat),
		.prog_data_pin_of_pair_out(pd_out), .prog_data_pin_of_pair_oe(pd_oe),
		.master_clear_pin_n(mrst_n), .debugger_pair_select(psel),
		.debug_enable(dbg_en), .prog_cmd(cmd), .prog_cmd_valid(cmd_v),
		.prog_resp_data(resp), .ctl_we(ctl_we), .ctl_wdata(wdat),
		.debug_port_control_reg(dpc), .debug_halt(halt), .periph_freeze(frz),
		.pin_in(pin_in), .gpio_out(g_out), .gpio_oe(g_oe), .pin_out(pin_out),
		.pin_oe(pin_oe));

	jtp_tester i_jtp_tester (
		.clk_sys(clk_sys), .tdo_out(tdo_out), .pd_out(pd_out), .pd_oe(pd_oe),
		.tck(tck), .tms(tms), .tdi(tdi), .mrst_n(mrst_n), .pclk(pclk), .pdat(pdat));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		if (cmd_v)
		begin
			nv++;
			last_cmd = cmd;
		end
		if (tdo_oe)
			oe_seen++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude;
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic do_reset;
		logic o;
		rstn = 1'b0;
		i_jtp_tester.wt(2);
		rstn = 1'b1;
		i_jtp_tester.wt(4);
		i_jtp_tester.step(1'b0, 1'b0, o);
	endtask : do_reset

	task automatic ctl_write(input logic [7:0] v);
		wdat = v;
		ctl_we = 1'b1;
		i_jtp_tester.wt(1);
		ctl_we = 1'b0;
		i_jtp_tester.wt(1);
	endtask : ctl_write

	// ----
	// Scenarios
	// ----
	task automatic t_id_bypass;
		chk(dpc, 8'h0c);
		chk(owned, 1'b1);
		chk(pin_out, 8'h96);
		chk(pin_oe, 8'h0f);
		i_jtp_tester.scan(1'b0, 32'h0, 32, q);
		chk(q, ID);
		i_jtp_tester.scan(1'b1, 32'hf, 4, q);
		chk(q[3:0], 4'b0001);
		i_jtp_tester.scan(1'b0, 32'hb5, 8, q);
		chk(q[7:0], 8'h6a);
		i_jtp_tester.scan(1'b1, 32'h8, 4, q);
		i_jtp_tester.scan(1'b0, 32'hb5, 8, q);
		chk(q[7:0], 8'h6a);
		i_jtp_tester.scan(1'b1, 32'h1, 4, q);
		i_jtp_tester.scan(1'b0, 32'h0, 32, q);
		chk(q, ID);
	endtask : t_id_bypass

	task automatic t_bscan;
		p = '0;
		pin_in = 8'h3a;
		g_out = 8'h5c;
		g_oe = 8'hf0;
		for (int i = 0; i < 8; i++)
		begin
			p[3*i+1] = i[0];
			p[3*i+2] = i[1];
		end
		i_jtp_tester.scan(1'b1, 32'h2, 4, q);
		i_jtp_tester.scan(1'b0, p, 24, q);
		for (int i = 0; i < 8; i++)
			chk(q[3*i], pin_in[i]);
		chk(pin_out, 8'h5c);
		chk(pin_oe, 8'hf0);
		i_jtp_tester.scan(1'b1, 32'h6, 4, q);
		i_jtp_tester.scan(1'b0, p, 24, q);
		chk(pin_out, 8'haa);
		chk(pin_oe, 8'hcc);
		i_jtp_tester.scan(1'b1, 32'h0, 4, q);
		chk(pin_oe, 8'h00);
		chk(pin_out, 8'h5c);
	endtask : t_bscan

	task automatic t_ctl;
		logic [2:0] fx [4];
		fx = '{3'b110, 3'b101, 3'b011, 3'b111};
		ctl_write(8'hff);
		chk(dpc, 8'h7c);
		ctl_write(8'h04);
		chk(owned, 1'b0);
		chk(pin_oe, 8'hf0);
		oe_seen = 0;
		i_jtp_tester.scan(1'b1, 32'hf, 4, q);
		chk(oe_seen, 0);
		halt = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			ctl_write(8'h08 | (8'h10 << k));
			chk(frz, fx[k]);
		end
		halt = 1'b0;
		i_jtp_tester.wt(1);
		chk(frz, 3'b000);
		do_reset();
		chk(dpc, 8'h0c);
		chk(owned, 1'b1);
	endtask : t_ctl

	task automatic t_prog;
		nv = 0;
		i_jtp_tester.mrst_n = 1'b0;
		i_jtp_tester.wt(4);
		i_jtp_tester.pbyte(1, 8'h3c, r);
		i_jtp_tester.wt(3);
		chk(last_cmd, 8'h3c);
		i_jtp_tester.pbyte(0, 8'h5a, r);
		i_jtp_tester.wt(4);
		chk(pd_oe, 2'b11);
		i_jtp_tester.pbyte(0, 8'h00, r);
		chk(r, 8'ha7);
		chk(nv, 2);
		i_jtp_tester.mrst_n = 1'b1;
		dbg_en = 1'b1;
		psel = 1'b1;
		i_jtp_tester.wt(4);
		i_jtp_tester.pbyte(0, 8'h11, r);
		i_jtp_tester.wt(4);
		chk(nv, 2);
		i_jtp_tester.pbyte(1, 8'h22, r);
		i_jtp_tester.wt(4);
		chk(last_cmd, 8'h22);
		resp = 8'h3b;
		i_jtp_tester.pbyte(1, 8'h5a, r);
		i_jtp_tester.wt(4);
		chk(pd_oe, 2'b10);
		i_jtp_tester.pbyte(1, 8'h00, r);
		chk(r, 8'h3b);
	endtask : t_prog

	initial
	begin
		{rstn, psel, dbg_en, ctl_we, halt} = '0;
		{wdat, last_cmd} = '0;
		resp = 8'ha7;
		pin_in = 8'hc5;
		g_out = 8'h96;
		g_oe = 8'h0f;
		{err_count, samples_checked, nv, oe_seen} = '0;
		do_reset();
		t_id_bypass();
		t_bscan();
		t_ctl();
		t_prog();
		conclude();
	end

	initial
	begin
		#2ms;
		err_count++;
		conclude();
	end
endmodule : jtp_top_tb
`default_nettype wire
